// >>> hw/odcc_pkg.sv
package odcc_pkg;

  // ----------------------------------------------------------------
  // Context population
  // ----------------------------------------------------------------
  localparam int NUM_ASYNC = 4;
  localparam int NUM_IT    = 8;
  localparam int NUM_CTX   = NUM_ASYNC + NUM_IT;
  localparam int CTX_IDX_W = 4;
  localparam int ADDR_W    = 12;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] ASYNC_TX_REQ_COMMAND_POINTER  = 12'h18C;
  localparam logic [11:0] ASYNC_TX_RESP_COMMAND_POINTER = 12'h1AC;
  localparam logic [11:0] ASYNC_RX_REQ_COMMAND_POINTER  = 12'h1CC;
  localparam logic [11:0] ASYNC_RX_RESP_COMMAND_POINTER = 12'h1EC;
  localparam logic [11:0] ASYNC_CTRL_SET_BASE           = 12'h180;
  localparam logic [11:0] ASYNC_STRIDE                  = 12'h020;
  localparam logic [11:0] ISO_TX_CONTEXT_CONTROL_SET    = 12'h200;
  localparam logic [11:0] ISO_TX_CONTEXT_CONTROL_CLEAR  = 12'h204;
  localparam logic [11:0] IT_STRIDE                     = 12'h010;
  localparam logic [11:0] CLEAR_OFS                     = 12'h004;
  localparam logic [11:0] CMD_PTR_OFS                   = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ARM_BIT     = 31;
  localparam int MATCH_LSB   = 16;
  localparam int MATCH_W     = 15;
  localparam int RUN_BIT     = 15;
  localparam int WAKE_BIT    = 12;
  localparam int DEAD_BIT    = 11;
  localparam int ACTIVE_BIT  = 10;
  localparam int DESC_LSB    = 4;
  localparam int DESC_W      = 28;
  localparam int COUNT_W     = 4;
  localparam int SEC_LSB     = 25;
  localparam int SEC_USED_W  = 2;
  localparam int CYC_LSB     = 12;
  localparam int CYC_W       = 13;

  // ----------------------------------------------------------------
  // Reset values and buffering
  // ----------------------------------------------------------------
  localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          FETCH_W     = CTX_IDX_W + DESC_W + COUNT_W;

endpackage

// >>> hw/odcc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module odcc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr_ptr;
    logic [PW:0]                 rd_ptr;
  } odcc_fifo_state_t;

  odcc_fifo_state_t st;
  odcc_fifo_state_t next_st;
  logic             full;
  logic             empty;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Extra pointer bit tells full from empty without a counter
  assign empty         = (st.wr_ptr == st.rd_ptr);
  assign full          = (st.wr_ptr[PW] != st.rd_ptr[PW]) &&
                         (st.wr_ptr[PW-1:0] == st.rd_ptr[PW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = st.mem[st.rd_ptr[PW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid_in && !full) begin
      next_st.mem[st.wr_ptr[PW-1:0]] = in_data_in;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// >>> hw/odcc_context_control.sv
// Contract
// - Setting run makes the first fetch use that context's command pointer.
// - Pointer bits 31-4 are a 16-byte aligned block address; low bits zero.
// - Pointer bits 3-0 count contiguous descriptors at the block address.
// - A zero descriptor count marks the block address invalid; no fetch.
// - Four async command pointers, software read/write, also updated by engine.
// - Eight iso transmit contexts, set/clear control pair every 16 bytes.
// - With arm set, first packet goes in the cycle equal to target value.
// - Compare uses two seconds bits and 13-bit cycle at cycle start.
// - Target is 15 bits at 30-16, against timer bits 26-25 and 24-12.
// - Armed context enables transmit only on timer equal target value.
// - First descriptor block may be fetched before the matching cycle.
// - Hardware clears the arm bit at the cycle match that enables transmit.
// - Hardware changes run only on hardware or software reset.
// - Software sets wake to resume; hardware clears it at every fetch.
// - Dead sets on fatal error, clears when software clears run.
// - Active is one while the context processes descriptors.
`timescale 1ns/1ps
`default_nettype none
module odcc_context_control (
  input  wire logic                           mclk_in,
  input  wire logic                           resetn_in,
  input  wire logic                           soft_reset_in,
  input  wire logic                           reg_sel_in,
  input  wire logic                           reg_write_in,
  input  wire logic [odcc_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [31:0]                    reg_wdata_in,
  output logic [31:0]                         reg_rdata_out,
  output logic                                reg_ack_out,
  input  wire logic                           cycle_start_in,
  input  wire logic [31:0]                    cycle_timer_in,
  input  wire logic                           ctx_done_in,
  input  wire logic                           ctx_error_in,
  input  wire logic [odcc_pkg::CTX_IDX_W-1:0] ctx_event_idx_in,
  input  wire logic                           ptr_update_in,
  input  wire logic [odcc_pkg::CTX_IDX_W-1:0] ptr_update_idx_in,
  input  wire logic [31:0]                    ptr_update_value_in,
  output logic                                fetch_valid_out,
  input  wire logic                           fetch_ready_in,
  output logic [odcc_pkg::CTX_IDX_W-1:0]      fetch_ctx_out,
  output logic [31:0]                         fetch_addr_out,
  output logic [odcc_pkg::COUNT_W-1:0]        fetch_count_out,
  output logic [odcc_pkg::NUM_CTX-1:0]        ctx_run_out,
  output logic [odcc_pkg::NUM_IT-1:0]         it_tx_enable_out
);

  typedef struct packed {
    logic [odcc_pkg::NUM_CTX-1:0][31:0]                 cmd_ptr;
    logic [odcc_pkg::NUM_CTX-1:0]                       run;
    logic [odcc_pkg::NUM_CTX-1:0]                       wake;
    logic [odcc_pkg::NUM_CTX-1:0]                       dead;
    logic [odcc_pkg::NUM_CTX-1:0]                       active;
    logic [odcc_pkg::NUM_CTX-1:0]                       pending;
    logic [odcc_pkg::NUM_IT-1:0]                        cycle_match_arm;
    logic [odcc_pkg::NUM_IT-1:0]                        wait_match;
    logic [odcc_pkg::NUM_IT-1:0]                        tx_enable;
    logic [odcc_pkg::NUM_IT-1:0][odcc_pkg::MATCH_W-1:0] target_cycle_value;
    logic [31:0]                                        rdata;
    logic                                               ack;
  } odcc_state_t;

  odcc_state_t                     st;
  odcc_state_t                     next_st;
  logic                            pick_found;
  logic [odcc_pkg::CTX_IDX_W-1:0]  pick_idx;
  logic [31:0]                     pick_ptr;
  logic                            push_valid;
  logic                            push_ready;
  logic [odcc_pkg::FETCH_W-1:0]    push_data;
  logic [odcc_pkg::FETCH_W-1:0]    pop_data;
  logic [odcc_pkg::MATCH_W-1:0]    timer_cycle;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] ctrl_set_addr(input int k);
    logic [11:0] a;
    a = 12'h000;
    if (k < odcc_pkg::NUM_ASYNC) begin
      a = odcc_pkg::ASYNC_CTRL_SET_BASE + odcc_pkg::ASYNC_STRIDE * 12'(k);
    end else begin
      a = odcc_pkg::ISO_TX_CONTEXT_CONTROL_SET +
          odcc_pkg::IT_STRIDE * 12'(k - odcc_pkg::NUM_ASYNC);
    end
    return a;
  endfunction

  // ----------------------------------------------------------------
  // Fetch selection
  // ----------------------------------------------------------------
  // Fixed priority: async contexts win over iso ones; a context
  // that keeps waking itself can starve higher indices.
  always_comb begin
    pick_found = 1'b0;
    pick_idx   = '0;
    pick_ptr   = odcc_pkg::PTR_RESET;
    for (int k = odcc_pkg::NUM_CTX - 1; k >= 0; k--) begin
      if (st.pending[k] && st.run[k]) begin
        pick_found = 1'b1;
        pick_idx   = odcc_pkg::CTX_IDX_W'(k);
        pick_ptr   = st.cmd_ptr[k];
      end
    end
  end

  // Count of zero means the address is not valid, so nothing is queued
  assign push_valid = pick_found && (pick_ptr[odcc_pkg::COUNT_W-1:0] != '0);
  assign push_data  = {pick_idx,
                       pick_ptr[odcc_pkg::DESC_LSB +: odcc_pkg::DESC_W],
                       pick_ptr[odcc_pkg::COUNT_W-1:0]};

  assign timer_cycle = {cycle_timer_in[odcc_pkg::SEC_LSB +: odcc_pkg::SEC_USED_W],
                        cycle_timer_in[odcc_pkg::CYC_LSB +: odcc_pkg::CYC_W]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    int          c;
    logic [11:0] set_a;
    logic [11:0] clr_a;
    logic [11:0] ptr_a;
    logic        wr;
    logic        rd;
    logic [31:0] word;
    next_st = st;
    c       = 0;
    set_a   = 12'h000;
    clr_a   = 12'h000;
    ptr_a   = 12'h000;
    word    = 32'h0000_0000;
    wr      = reg_sel_in && reg_write_in;
    rd      = reg_sel_in && !reg_write_in;
    next_st.ack = reg_sel_in;

    // Engine finished a context; a same-cycle new fetch keeps it active
    if (ctx_done_in && (32'(ctx_event_idx_in) < odcc_pkg::NUM_CTX)) begin
      next_st.active[ctx_event_idx_in] = 1'b0;
    end

    // Queue or discard the selected fetch
    if (pick_found && (!push_valid || push_ready)) begin
      next_st.pending[pick_idx] = 1'b0;
      if (push_valid) begin
        next_st.wake[pick_idx] = 1'b0;
        next_st.active[pick_idx] = 1'b1;
      end
    end

    // Register writes
    for (int k = 0; k < odcc_pkg::NUM_CTX; k++) begin
      set_a = ctrl_set_addr(k);
      clr_a = set_a + odcc_pkg::CLEAR_OFS;
      ptr_a = set_a + odcc_pkg::CMD_PTR_OFS;
      if (wr && reg_addr_in == set_a) begin
        if (k >= odcc_pkg::NUM_ASYNC) begin
          c = k - odcc_pkg::NUM_ASYNC;
          next_st.cycle_match_arm[c] = st.cycle_match_arm[c] |
                                       reg_wdata_in[odcc_pkg::ARM_BIT];
          next_st.target_cycle_value[c] = st.target_cycle_value[c] |
              reg_wdata_in[odcc_pkg::MATCH_LSB +: odcc_pkg::MATCH_W];
        end
        if (reg_wdata_in[odcc_pkg::RUN_BIT] && !st.run[k]) begin
          next_st.run[k]     = 1'b1;
          next_st.pending[k] = 1'b1;
          if (k >= odcc_pkg::NUM_ASYNC) begin
            // Fetch goes ahead now, transmit waits for the match only if arm is set
            next_st.wait_match[c] = next_st.cycle_match_arm[c];
          end
        end
        if (reg_wdata_in[odcc_pkg::WAKE_BIT]) begin
          next_st.wake[k] = 1'b1;
          if (st.run[k]) begin
            next_st.pending[k] = 1'b1;
          end
        end
      end else if (wr && reg_addr_in == clr_a) begin
        if (k >= odcc_pkg::NUM_ASYNC) begin
          c = k - odcc_pkg::NUM_ASYNC;
          next_st.cycle_match_arm[c] = st.cycle_match_arm[c] &
                                       ~reg_wdata_in[odcc_pkg::ARM_BIT];
          next_st.target_cycle_value[c] = st.target_cycle_value[c] &
              ~reg_wdata_in[odcc_pkg::MATCH_LSB +: odcc_pkg::MATCH_W];
        end
        if (reg_wdata_in[odcc_pkg::RUN_BIT]) begin
          next_st.run[k]     = 1'b0;
          next_st.dead[k]    = 1'b0;
          next_st.active[k]  = 1'b0;
          next_st.pending[k] = 1'b0;
          if (k >= odcc_pkg::NUM_ASYNC) begin
            next_st.wait_match[c] = 1'b0;
          end
        end
      end else if (wr && reg_addr_in == ptr_a && k < odcc_pkg::NUM_ASYNC) begin
        next_st.cmd_ptr[k] = reg_wdata_in;
      end
    end

    // Cycle match at each cycle start
    for (int n = 0; n < odcc_pkg::NUM_IT; n++) begin
      c = n + odcc_pkg::NUM_ASYNC;
      if (cycle_start_in && st.run[c] && st.wait_match[n] &&
          timer_cycle == st.target_cycle_value[n]) begin
        next_st.wait_match[n]      = 1'b0;
        next_st.active[c]          = 1'b1;
        next_st.cycle_match_arm[n] = 1'b0;
      end
    end

    // Hardware set wins over a same-cycle run clear
    if (ctx_error_in && (32'(ctx_event_idx_in) < odcc_pkg::NUM_CTX)) begin
      next_st.dead[ctx_event_idx_in]   = 1'b1;
      next_st.active[ctx_event_idx_in] = 1'b0;
    end

    // Engine pointer update wins over a software write
    if (ptr_update_in && (32'(ptr_update_idx_in) < odcc_pkg::NUM_CTX)) begin
      next_st.cmd_ptr[ptr_update_idx_in] = ptr_update_value_in;
    end

    // Only a reset takes run away from software
    if (soft_reset_in) begin
      next_st.run        = '0;
      next_st.pending    = '0;
      next_st.active     = '0;
      next_st.dead       = '0;
      next_st.wait_match = '0;
    end

    for (int n = 0; n < odcc_pkg::NUM_IT; n++) begin
      c = n + odcc_pkg::NUM_ASYNC;
      next_st.tx_enable[n] = next_st.run[c] && !next_st.wait_match[n] &&
                             !next_st.dead[c];
    end

    // Register reads: both set and clear addresses show the value
    if (rd) begin
      next_st.rdata = odcc_pkg::RDATA_RESET;
      for (int k = 0; k < odcc_pkg::NUM_CTX; k++) begin
        set_a = ctrl_set_addr(k);
        clr_a = set_a + odcc_pkg::CLEAR_OFS;
        ptr_a = set_a + odcc_pkg::CMD_PTR_OFS;
        if (reg_addr_in == set_a || reg_addr_in == clr_a) begin
          word = 32'h0000_0000;
          word[odcc_pkg::RUN_BIT]    = st.run[k];
          word[odcc_pkg::WAKE_BIT]   = st.wake[k];
          word[odcc_pkg::DEAD_BIT]   = st.dead[k];
          word[odcc_pkg::ACTIVE_BIT] = st.active[k];
          if (k >= odcc_pkg::NUM_ASYNC) begin
            c = k - odcc_pkg::NUM_ASYNC;
            word[odcc_pkg::ARM_BIT] = st.cycle_match_arm[c];
            word[odcc_pkg::MATCH_LSB +: odcc_pkg::MATCH_W] = st.target_cycle_value[c];
          end
          next_st.rdata = word;
        end else if (reg_addr_in == ptr_a) begin
          next_st.rdata = st.cmd_ptr[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Fetch queue
  // ----------------------------------------------------------------
  odcc_fifo #(
    .WIDTH (odcc_pkg::FETCH_W),
    .DEPTH (odcc_pkg::FIFO_DEPTH)
  ) u_fetch_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (fetch_valid_out),
    .out_ready_in  (fetch_ready_in),
    .out_data_out  (pop_data)
  );

  // Low four address bits are implied zero
  assign fetch_ctx_out    = pop_data[odcc_pkg::FETCH_W-1 -: odcc_pkg::CTX_IDX_W];
  assign fetch_addr_out   = {pop_data[odcc_pkg::COUNT_W +: odcc_pkg::DESC_W],
                             4'h0};
  assign fetch_count_out  = pop_data[odcc_pkg::COUNT_W-1:0];
  assign reg_rdata_out    = st.rdata;
  assign reg_ack_out      = st.ack;
  assign ctx_run_out      = st.run;
  assign it_tx_enable_out = st.tx_enable;

endmodule
`default_nettype wire

// >>> test/odcc_context_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module odcc_context_control_sva (
  input wire logic        mclk_in,
  input wire logic        resetn_in,
  input wire logic        soft_reset_in,
  input wire logic        reg_sel_in,
  input wire logic        reg_write_in,
  input wire logic        reg_ack_out,
  input wire logic        cycle_start_in,
  input wire logic        fetch_valid_out,
  input wire logic        fetch_ready_in,
  input wire logic [3:0]  fetch_ctx_out,
  input wire logic [31:0] fetch_addr_out,
  input wire logic [3:0]  fetch_count_out,
  input wire logic [11:0] ctx_run_out,
  input wire logic [7:0]  it_tx_enable_out
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire wr = reg_sel_in && reg_write_in;
  AST_ACK: assert property (reg_sel_in |=> reg_ack_out)
    else $error("access not acknowledged");
  AST_NO_ACK: assert property (!reg_sel_in |=> !reg_ack_out)
    else $error("acknowledge without access");
  AST_ALIGN: assert property (fetch_valid_out |-> fetch_addr_out[3:0] == 4'h0)
    else $error("fetch address not aligned");
  AST_COUNT: assert property (fetch_valid_out |-> fetch_count_out != 4'h0)
    else $error("fetch with zero count");
  AST_HOLD: assert property (fetch_valid_out && !fetch_ready_in && !soft_reset_in
    |=> fetch_valid_out && $stable({fetch_ctx_out, fetch_addr_out, fetch_count_out}))
    else $error("stalled fetch head changed");
  AST_RUN: assert property (!wr && !soft_reset_in |=> $stable(ctx_run_out))
    else $error("run changed on its own");
  AST_TXEN_RUN: assert property (
    (it_tx_enable_out & ~ctx_run_out[11:4]) == 8'h00)
    else $error("transmit enabled without run");
  AST_TXEN_CAUSE: assert property ((|(it_tx_enable_out & ~$past(it_tx_enable_out)))
    |-> $past(wr) || $past(wr, 2) || $past(cycle_start_in) || $past(cycle_start_in, 2))
    else $error("transmit enable rose without cause");
endmodule
bind odcc_context_control odcc_context_control_sva odcc_context_control_sva_i (
  .mclk_in, .resetn_in, .soft_reset_in, .reg_sel_in, .reg_write_in, .reg_ack_out,
  .cycle_start_in, .fetch_valid_out, .fetch_ready_in, .fetch_ctx_out, .fetch_addr_out,
  .fetch_count_out, .ctx_run_out, .it_tx_enable_out);
`default_nettype wire

// >>> test/odcc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module odcc_engine_model (
  input  wire logic        mclk_in,
  input  wire logic        stall_in,
  input  wire logic        fetch_valid_in,
  input  wire logic [3:0]  fetch_ctx_in,
  input  wire logic [31:0] fetch_addr_in,
  input  wire logic [3:0]  fetch_count_in,
  output logic             ready_out
);
  // ----------------------------------------------------------------
  // Fetch sink: takes entries early, before any cycle match
  // ----------------------------------------------------------------
  logic [39:0] q[$];
  assign ready_out = !stall_in;
  always @(posedge mclk_in) begin
    if (fetch_valid_in && ready_out) begin
      q.push_back({fetch_ctx_in, fetch_addr_in, fetch_count_in});
    end
  end
endmodule
`default_nettype wire

// >>> test/odcc_context_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odcc_context_control_tb;
  logic mclk_in = 0, resetn_in = 0, soft_reset_in = 0, reg_sel_in = 0, reg_write_in = 0;
  logic cycle_start_in = 0, ctx_done_in = 0, ctx_error_in = 0, ptr_update_in = 0, stall = 0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0, cycle_timer_in = 32'h0, ptr_update_value_in = 32'h0;
  logic [3:0]  ctx_event_idx_in = 4'h0, ptr_update_idx_in = 4'h0;
  logic [31:0] reg_rdata_out, fetch_addr_out;
  logic        reg_ack_out, fetch_valid_out, fetch_ready_in;
  logic [3:0]  fetch_ctx_out, fetch_count_out;
  logic [11:0] ctx_run_out;
  logic [7:0]  it_tx_enable_out;
  int          err_count = 0, n_checks = 0;

  odcc_context_control odcc_context_control_i (.mclk_in, .resetn_in, .soft_reset_in,
    .reg_sel_in, .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out,
    .cycle_start_in, .cycle_timer_in, .ctx_done_in, .ctx_error_in, .ctx_event_idx_in,
    .ptr_update_in, .ptr_update_idx_in, .ptr_update_value_in, .fetch_valid_out,
    .fetch_ready_in, .fetch_ctx_out, .fetch_addr_out, .fetch_count_out, .ctx_run_out,
    .it_tx_enable_out);
  odcc_engine_model odcc_engine_model_i (.mclk_in, .stall_in(stall),
    .fetch_valid_in(fetch_valid_out), .fetch_ctx_in(fetch_ctx_out),
    .fetch_addr_in(fetch_addr_out), .fetch_count_in(fetch_count_out),
    .ready_out(fetch_ready_in));

  always #25 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk_in);
    reg_sel_in = 1'b1;
    reg_write_in = w;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge mclk_in);
    reg_sel_in = 1'b0;
    chk(reg_ack_out, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(reg_rdata_out, e);
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 40 && odcc_engine_model_i.q.size() < n; i++) @(negedge mclk_in);
    chk(odcc_engine_model_i.q.size(), n);
  endtask
  task automatic cyc(input logic [31:0] t);
    @(negedge mclk_in);
    cycle_start_in = 1'b1;
    cycle_timer_in = t;
    @(negedge mclk_in);
    cycle_start_in = 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_async;
    chk({fetch_valid_out, it_tx_enable_out, ctx_run_out}, 40'h0);
    rd(12'h18C, 32'h0);
    for (int k = 0; k < 4; k++) acc(1'b1, 12'h18C + 12'(k * 32), 32'h1000_0003 + 32'(k << 4));
    for (int k = 0; k < 4; k++) rd(12'h18C + 12'(k * 32), 32'h1000_0003 + 32'(k << 4));
    acc(1'b1, 12'h1CC, 32'h3000_0040);
    acc(1'b1, 12'h7FC, 32'hFFFF_FFFF);
    rd(12'h7FC, 32'h0);
    acc(1'b1, 12'h1A0, 32'h0000_8000);
    wait_q(1);
    chk(odcc_engine_model_i.q[0], {4'h1, 32'h1000_0010, 4'h3});
    rd(12'h1A0, 32'h0000_8400);
    acc(1'b1, 12'h1C0, 32'h0000_8000);
    repeat (6) @(negedge mclk_in);
    chk(odcc_engine_model_i.q.size(), 1);
    rd(12'h1C0, 32'h0000_8000);
    acc(1'b1, 12'h1C4, 32'h0000_8000);
    rd(12'h1C0, 32'h0000_0000);
    acc(1'b1, 12'h1A0, 32'h0000_1000);
    wait_q(2);
    rd(12'h1A0, 32'h0000_8400);
    @(negedge mclk_in);
    ctx_done_in = 1'b1;
    ctx_event_idx_in = 4'h1;
    @(negedge mclk_in);
    ctx_done_in = 1'b0;
    rd(12'h1A0, 32'h0000_8000);
    $display("test async done");
  endtask
  task automatic t_fifo;
    odcc_engine_model_i.q.delete();
    stall = 1'b1;
    repeat (10) acc(1'b1, 12'h1A0, 32'h0000_1000);
    chk(fetch_valid_out, 1'b1);
    chk(odcc_engine_model_i.q.size(), 0);
    stall = 1'b0;
    wait_q(9);
    repeat (4) @(negedge mclk_in);
    chk(odcc_engine_model_i.q.size(), 9);
    $display("test fifo done");
  endtask
  task automatic t_iso;
    odcc_engine_model_i.q.delete();
    @(negedge mclk_in);
    ptr_update_in = 1'b1;
    ptr_update_idx_in = 4'h4;
    ptr_update_value_in = 32'h2000_0001;
    @(negedge mclk_in);
    ptr_update_in = 1'b0;
    rd(12'h20C, 32'h2000_0001);
    acc(1'b1, 12'h200, 32'hD234_8000);
    wait_q(1);
    chk(odcc_engine_model_i.q[0], {4'h4, 32'h2000_0000, 4'h1});
    chk(it_tx_enable_out[0], 1'b0);
    cyc(32'h0523_6000);
    chk(it_tx_enable_out[0], 1'b0);
    cyc(32'h0D23_4000);
    chk(it_tx_enable_out[0], 1'b1);
    rd(12'h200, 32'h5234_8400);
    acc(1'b1, 12'h210, 32'h0000_8000);
    repeat (2) @(negedge mclk_in);
    chk(it_tx_enable_out[1], 1'b1);
    @(negedge mclk_in);
    ctx_error_in = 1'b1;
    ctx_event_idx_in = 4'h4;
    @(negedge mclk_in);
    ctx_error_in = 1'b0;
    rd(12'h200, 32'h5234_8800);
    chk(it_tx_enable_out[0], 1'b0);
    acc(1'b1, 12'h204, 32'h0000_8000);
    rd(12'h200, 32'h5234_0000);
    @(negedge mclk_in);
    soft_reset_in = 1'b1;
    @(negedge mclk_in);
    soft_reset_in = 1'b0;
    chk(ctx_run_out, 12'h000);
    rd(12'h210, 32'h0);
    $display("test iso done");
  endtask

  initial begin
    repeat (6) @(negedge mclk_in);
    resetn_in = 1'b1;
    t_async();
    t_fifo();
    t_iso();
    print_verdict();
  end
  // Limit is far above the hundred or so cycles the tests need
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
